/* pflk_pkg.sv */
/*
 * Shared constants and types of the parallel flash programming port with lock
 * protection. Assumes a single 50 MHz clock and pin levels that the port
 * module synchronises itself.
 */
package pflk_pkg;

	// Clock and timing.
	localparam int unsigned CLK_MHZ        = 50;
	localparam int unsigned WRITE_TIME_US  = 1500;
	localparam int unsigned ERASE_TIME_US  = 10000;
	localparam int unsigned WRITE_CYCLES   = WRITE_TIME_US * CLK_MHZ;
	localparam int unsigned ERASE_CYCLES   = ERASE_TIME_US * CLK_MHZ;
	localparam int unsigned TCNT_W         = 20;

	// Code array geometry.
	localparam int unsigned ARRAY_BYTES    = 20480;
	localparam int unsigned ADDR_W         = 15;
	localparam logic [7:0]  BLANK_BYTE     = 8'hFF;

	// Signature locations and the programming-voltage marker.
	localparam logic [14:0] SIG_MAKER_ADR  = 15'h0030;
	localparam logic [14:0] SIG_PART_ADR   = 15'h0031;
	localparam logic [14:0] SIG_VPP_ADR    = 15'h0032;
	localparam logic [7:0]  SIG_VPP_12V    = 8'hFF;

	// Select patterns {sel_a, sel_b, ssel_low, ssel_high}.
	localparam logic [3:0]  PAT_WR_CODE    = 4'h7;
	localparam logic [3:0]  PAT_RD_CODE    = 4'h3;
	localparam logic [3:0]  PAT_LOCK1      = 4'hF;
	localparam logic [3:0]  PAT_LOCK2      = 4'hC;
	localparam logic [3:0]  PAT_LOCK3      = 4'hA;
	localparam logic [3:0]  PAT_ERASE      = 4'h8;
	localparam logic [3:0]  PAT_SIG        = 4'h0;

	// Register map on the bus.
	localparam logic [7:0]  REG_CTRL       = 8'h00;
	localparam logic [7:0]  REG_STATUS     = 8'h04;
	localparam int unsigned CTRL_PORT_EN   = 0;
	localparam logic        CTRL_RESET     = 1'b1;
	localparam int unsigned ST_BUSY        = 0;
	localparam int unsigned ST_PROG_MODE   = 1;
	localparam int unsigned ST_ERASING     = 2;
	localparam int unsigned ST_EA_EFF      = 3;
	localparam int unsigned ST_LEVEL_LSB   = 4;

	// Programming pins as seen by the device.
	typedef struct packed {
		logic        prog_reset;
		logic        code_fetch_strobe_n;
		logic        latch_program_strobe;
		logic        ea_level;
		logic        vpp_high;
		logic        high_port_select_a;
		logic        high_port_select_b;
		logic        strobe_select_low_pin;
		logic        strobe_select_high_pin;
		logic        serial_receive_pin;
		logic [13:0] addr;
		logic [7:0]  data;
	} pflk_pins_t;

	localparam int unsigned PINS_W = $bits(pflk_pins_t);

	typedef enum logic [2:0] {
		OP_NONE    = 3'b000,
		OP_WR_CODE = 3'b001,
		OP_RD_CODE = 3'b010,
		OP_LOCK1   = 3'b011,
		OP_LOCK2   = 3'b100,
		OP_LOCK3   = 3'b101,
		OP_ERASE   = 3'b110,
		OP_SIG     = 3'b111
	} pflk_op_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_WRITE = 2'b01,
		ST_ERASE = 2'b10
	} pflk_state_t;

endpackage : pflk_pkg

/* pflk_sync.sv */
/*
 * Three-stage pin synchroniser. Assumes asynchronous inputs; a bit changes
 * at the output only once the second and third stages agree.
 */
`timescale 1ns/100ps
module pflk_sync #(
	parameter int unsigned       WIDTH     = 1,
	parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
	// Clock and reset.
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Raw and settled levels.
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] stable_o
);

	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1 <= RESET_VAL;
			s2 <= RESET_VAL;
			s3 <= RESET_VAL;
		end else begin
			s1 <= async_i;
			s2 <= s1;
			s3 <= s2;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stable_o <= RESET_VAL;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (s2[i] == s3[i]) begin
					stable_o[i] <= s3[i];
				end
			end
		end
	end

endmodule : pflk_sync

/* pflk_wb_regs.sv */
/*
 * Classic Wishbone slave with the control and status registers of the flash
 * port. Assumes a single-cycle master that holds its request until ack.
 */
`timescale 1ns/100ps
module pflk_wb_regs (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave.
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Block side.
	input  wire logic [7:0]  status_i,
	output logic             port_en_o
);

	logic req;

	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	// Every access, mapped or not, is answered one cycle after it is seen.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_en_o <= pflk_pkg::CTRL_RESET;
		end else if (req & wb_we_i & wb_sel_i[0] & (wb_adr_i == pflk_pkg::REG_CTRL)) begin
			port_en_o <= wb_dat_i[pflk_pkg::CTRL_PORT_EN];
		end
	end

	// Unmapped addresses read as zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (req & ~wb_we_i) begin
			unique case (wb_adr_i)
				pflk_pkg::REG_CTRL:   wb_dat_o <= {31'h00000000, port_en_o};
				pflk_pkg::REG_STATUS: wb_dat_o <= {24'h000000, status_i};
				default:              wb_dat_o <= 32'h00000000;
			endcase
		end
	end

endmodule : pflk_wb_regs

/* pflk_flash_port.sv */
/*
 * On-chip code flash with its parallel programming port and three-bit lock
 * protection, plus the core-side read port that the locks gate.
 * Assumes pins arrive asynchronously and a Wishbone master on clk_i.
 */
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/100ps
module pflk_flash_port #(
	parameter int unsigned WRITE_CYCLES = pflk_pkg::WRITE_CYCLES,
	parameter int unsigned ERASE_CYCLES = pflk_pkg::ERASE_CYCLES,
	parameter int unsigned ARRAY_BYTES  = pflk_pkg::ARRAY_BYTES,
	// Identity values are arbitrary.
	parameter logic [7:0]  MAKER_CODE   = 8'hA5,
	parameter logic [7:0]  PART_CODE    = 8'h5A,
	// Power-up content of the access-level latch; any value is legal.
	parameter logic        EA_POWERUP   = 1'b1
) (
	// Clock and reset.
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Programming pins.
	input  wire pflk_pkg::pflk_pins_t pins_i,
	output logic [7:0]                data_o,
	output logic                      data_oe_o,
	output logic                      ready_busy_pin_o,
	output logic                      ready_busy_pin_oe_o,
	// Core-side code read port.
	input  wire logic [14:0]          cpu_addr_i,
	input  wire logic                 cpu_from_ext_i,
	output logic [7:0]                cpu_code_o,
	output logic                      cpu_read_ok_o,
	output logic                      ext_exec_allowed_o,
	// Wishbone slave.
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic [31:0]               wb_dat_o,
	output logic                      wb_ack_o
);

	localparam int unsigned TW = pflk_pkg::TCNT_W;
	localparam int unsigned AW = pflk_pkg::ADDR_W;
	localparam logic [TW-1:0] WRITE_CNT = TW'(WRITE_CYCLES);
	localparam logic [TW-1:0] ERASE_CNT = TW'(ERASE_CYCLES);
	localparam logic [AW-1:0] LAST_ADR  = AW'(ARRAY_BYTES - 1);
	// The strobe pin idles high, so its settled copy starts high and no false edge follows reset.
	localparam pflk_pkg::pflk_pins_t PIN_IDLE = '{latch_program_strobe: 1'b1, default: '0};

	logic [7:0]             mem [ARRAY_BYTES];
	pflk_pkg::pflk_pins_t   pin;
	logic [pflk_pkg::PINS_W-1:0] pin_vec;
	pflk_pkg::pflk_state_t  state;
	pflk_pkg::pflk_op_t     op;
	logic                   port_en;
	logic                   prog_mode;
	logic                   strobe_q;
	logic                   strobe_rise;
	logic [TW-1:0]          low_cnt;
	logic [TW-1:0]          timer;
	logic [AW-1:0]          prog_adr;
	logic [AW-1:0]          wr_adr;
	logic [7:0]             wr_data;
	pflk_pkg::pflk_op_t     wr_op;
	logic [AW-1:0]          sweep_adr;
	logic                   lock_bit_one;
	logic                   lock_bit_two;
	logic                   lock_bit_three;
	logic                   ea_hold;
	logic                   ea_eff;
	logic                   busy;
	logic                   mem_we;
	logic [AW-1:0]          mem_wa;
	logic [7:0]             mem_wd;
	logic [7:0]             prog_rd;
	logic                   prog_rd_ok;
	logic [7:0]             next_data;
	logic [7:0]             status;

	pflk_sync #(
		.WIDTH     (pflk_pkg::PINS_W),
		.RESET_VAL (PIN_IDLE)
	) u_sync (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.async_i  (pins_i),
		.stable_o (pin_vec)
	);

	assign pin = pflk_pkg::pflk_pins_t'(pin_vec);

	pflk_wb_regs u_regs (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.wb_cyc_i  (wb_cyc_i),
		.wb_stb_i  (wb_stb_i),
		.wb_we_i   (wb_we_i),
		.wb_adr_i  (wb_adr_i),
		.wb_sel_i  (wb_sel_i),
		.wb_dat_i  (wb_dat_i),
		.wb_dat_o  (wb_dat_o),
		.wb_ack_o  (wb_ack_o),
		.status_i  (status),
		.port_en_o (port_en)
	);

	// Programming mode needs reset held high and the fetch strobe low.
	assign prog_mode = port_en & pin.prog_reset & ~pin.code_fetch_strobe_n;
	assign prog_adr  = {pin.serial_receive_pin, pin.addr};
	assign busy      = (state != pflk_pkg::ST_IDLE);

	always_comb begin
		unique case ({pin.high_port_select_a, pin.high_port_select_b,
				pin.strobe_select_low_pin, pin.strobe_select_high_pin})
			pflk_pkg::PAT_WR_CODE: op = pflk_pkg::OP_WR_CODE;
			pflk_pkg::PAT_RD_CODE: op = pflk_pkg::OP_RD_CODE;
			pflk_pkg::PAT_LOCK1:   op = pflk_pkg::OP_LOCK1;
			pflk_pkg::PAT_LOCK2:   op = pflk_pkg::OP_LOCK2;
			pflk_pkg::PAT_LOCK3:   op = pflk_pkg::OP_LOCK3;
			pflk_pkg::PAT_ERASE:   op = pflk_pkg::OP_ERASE;
			pflk_pkg::PAT_SIG:     op = pflk_pkg::OP_SIG;
			default:               op = pflk_pkg::OP_NONE;
		endcase
	end

	// Strobe edges and the length of its low phase.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strobe_q <= 1'b1;
		end else begin
			strobe_q <= pin.latch_program_strobe;
		end
	end

	assign strobe_rise = ~strobe_q & pin.latch_program_strobe;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_cnt <= '0;
		end else if (pin.latch_program_strobe | ~prog_mode) begin
			low_cnt <= '0;
		end else if (low_cnt != ERASE_CNT) begin
			low_cnt <= low_cnt + TW'(1);
		end
	end

	// Sequencer. A pulse is accepted only while idle, with the high voltage on.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state     <= pflk_pkg::ST_ERASE;
			sweep_adr <= '0;
			timer     <= '0;
			wr_adr    <= '0;
			wr_data   <= pflk_pkg::BLANK_BYTE;
			wr_op     <= pflk_pkg::OP_NONE;
		end else begin
			unique case (state)
				pflk_pkg::ST_IDLE: begin
					if (strobe_rise & prog_mode & pin.vpp_high) begin
						if (op == pflk_pkg::OP_ERASE && low_cnt == ERASE_CNT) begin
							state     <= pflk_pkg::ST_ERASE;
							sweep_adr <= '0;
						end else if ((op == pflk_pkg::OP_WR_CODE && !lock_bit_one) ||
								op == pflk_pkg::OP_LOCK1 || op == pflk_pkg::OP_LOCK2 ||
								op == pflk_pkg::OP_LOCK3) begin
							state   <= pflk_pkg::ST_WRITE;
							timer   <= WRITE_CNT;
							wr_adr  <= prog_adr;
							wr_data <= pin.data;
							wr_op   <= op;
						end
					end
				end
				pflk_pkg::ST_WRITE: begin
					// Further strobes are not looked at until the write ends.
					if (timer == TW'(1)) begin
						state <= pflk_pkg::ST_IDLE;
					end
					timer <= timer - TW'(1);
				end
				pflk_pkg::ST_ERASE: begin
					if (sweep_adr == LAST_ADR) begin
						state <= pflk_pkg::ST_IDLE;
					end
					sweep_adr <= sweep_adr + AW'(1);
				end
				default: begin
					state <= pflk_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Lock bits start unprogrammed and are cleared by every erase.
	always_ff @(posedge clk_i) begin
		if (rst_i || state == pflk_pkg::ST_ERASE) begin
			lock_bit_one   <= 1'b0;
			lock_bit_two   <= 1'b0;
			lock_bit_three <= 1'b0;
		end else if (state == pflk_pkg::ST_WRITE && timer == TW'(1)) begin
			if (wr_op == pflk_pkg::OP_LOCK1) begin
				lock_bit_one <= 1'b1;
			end
			if (wr_op == pflk_pkg::OP_LOCK2) begin
				lock_bit_two <= 1'b1;
			end
			if (wr_op == pflk_pkg::OP_LOCK3) begin
				lock_bit_three <= 1'b1;
			end
		end
	end

	// Array writes. A byte write can only clear bits, so a set bit needs an erase.
	always_comb begin
		mem_we = 1'b0;
		mem_wa = wr_adr;
		mem_wd = mem[wr_adr] & wr_data;
		if (state == pflk_pkg::ST_ERASE) begin
			mem_we = 1'b1;
			mem_wa = sweep_adr;
			mem_wd = pflk_pkg::BLANK_BYTE;
		end else if (state == pflk_pkg::ST_WRITE && timer == TW'(1) &&
				wr_op == pflk_pkg::OP_WR_CODE && wr_adr <= LAST_ADR) begin
			mem_we = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end

	// Programming-side array read, blank beyond the array.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prog_rd    <= pflk_pkg::BLANK_BYTE;
			prog_rd_ok <= 1'b0;
		end else begin
			prog_rd    <= (prog_adr <= LAST_ADR) ? mem[prog_adr] : pflk_pkg::BLANK_BYTE;
			prog_rd_ok <= (prog_adr <= LAST_ADR);
		end
	end

	// Data lines: polling, verify and signature reads.
	always_comb begin
		next_data = pflk_pkg::BLANK_BYTE;
		if (op == pflk_pkg::OP_SIG) begin
			unique case (prog_adr)
				pflk_pkg::SIG_MAKER_ADR: next_data = MAKER_CODE;
				pflk_pkg::SIG_PART_ADR:  next_data = PART_CODE;
				pflk_pkg::SIG_VPP_ADR:   next_data = pflk_pkg::SIG_VPP_12V;
				default:                 next_data = pflk_pkg::BLANK_BYTE;
			endcase
		end else if (op == pflk_pkg::OP_RD_CODE) begin
			if (state == pflk_pkg::ST_WRITE && wr_op == pflk_pkg::OP_WR_CODE &&
					prog_adr == wr_adr) begin
				next_data = {~wr_data[7], wr_data[6:0]};
			end else if (lock_bit_one & lock_bit_two) begin
				next_data = pflk_pkg::BLANK_BYTE;
			end else if (prog_rd_ok) begin
				next_data = prog_rd;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_o    <= pflk_pkg::BLANK_BYTE;
			data_oe_o <= 1'b0;
		end else begin
			data_o    <= next_data;
			data_oe_o <= prog_mode & ~pin.vpp_high &
				(op == pflk_pkg::OP_RD_CODE || op == pflk_pkg::OP_SIG);
		end
	end

	// Busy reaches the pin one clock after the sequencer leaves idle, two after the accepting strobe edge.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ready_busy_pin_o    <= 1'b0;
			ready_busy_pin_oe_o <= 1'b0;
		end else begin
			ready_busy_pin_o    <= ~busy;
			ready_busy_pin_oe_o <= prog_mode;
		end
	end

	// Access level caught while the reset pin is high, once lock one is set.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ea_hold <= EA_POWERUP;
		end else if (lock_bit_one & pin.prog_reset) begin
			ea_hold <= pin.ea_level;
		end
	end

	assign ea_eff = lock_bit_one ? ea_hold : pin.ea_level;

	// Core-side reads and the external execution gate.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cpu_code_o         <= pflk_pkg::BLANK_BYTE;
			cpu_read_ok_o      <= 1'b0;
			ext_exec_allowed_o <= 1'b0;
		end else begin
			cpu_read_ok_o      <= ~(lock_bit_one & cpu_from_ext_i);
			if (lock_bit_one & cpu_from_ext_i) begin
				cpu_code_o <= pflk_pkg::BLANK_BYTE;
			end else if (cpu_addr_i <= LAST_ADR) begin
				cpu_code_o <= mem[cpu_addr_i];
			end else begin
				cpu_code_o <= pflk_pkg::BLANK_BYTE;
			end
			ext_exec_allowed_o <= ~ea_eff & ~lock_bit_three & ~pin.prog_reset;
		end
	end

	always_comb begin
		status = '0;
		status[pflk_pkg::ST_BUSY]      = busy;
		status[pflk_pkg::ST_PROG_MODE] = prog_mode;
		status[pflk_pkg::ST_ERASING]   = (state == pflk_pkg::ST_ERASE);
		status[pflk_pkg::ST_EA_EFF]    = ea_eff;
		status[pflk_pkg::ST_LEVEL_LSB +: 2] = lock_bit_three ? 2'h3 :
			lock_bit_two & lock_bit_one ? 2'h2 : lock_bit_one ? 2'h1 : 2'h0;
	end

endmodule : pflk_flash_port

/* pflk_properties.sv */
/*
 * Concurrent checks on the ports of the flash programming port.
 * Assumes the programmer settles its pins several cycles before each strobe edge.
 */
`timescale 1ns/100ps
module pflk_properties #(
	parameter int unsigned WRITE_CYCLES = 20,
	parameter int unsigned ERASE_CYCLES = 30,
	parameter int unsigned ARRAY_BYTES  = 64
) (
	// Clock and reset.
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Programming pins.
	input  wire pflk_pkg::pflk_pins_t pins_i,
	input  wire logic                 data_oe_o,
	input  wire logic                 ready_busy_pin_o,
	input  wire logic                 ready_busy_pin_oe_o,
	// Core port.
	input  wire logic                 cpu_from_ext_i,
	input  wire logic [7:0]           cpu_code_o,
	input  wire logic                 cpu_read_ok_o,
	input  wire logic                 ext_exec_allowed_o,
	// Wishbone.
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_ack_o
);
	localparam int unsigned RB_MAX = 2 * WRITE_CYCLES + ERASE_CYCLES + ARRAY_BYTES + 20;
	logic [3:0]  pat;
	int unsigned low_cnt;
	assign pat = {pins_i.high_port_select_a, pins_i.high_port_select_b,
		pins_i.strobe_select_low_pin, pins_i.strobe_select_high_pin};
	// Counts the cycles that the ready/busy pin has been driven low.
	always_ff @(posedge clk_i) begin
		if (rst_i || ready_busy_pin_o || !ready_busy_pin_oe_o) begin
			low_cnt <= 0;
		end else begin
			low_cnt <= low_cnt + 1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered in one cycle");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack longer than one cycle");
	AST_LOCK_BUSY: assert property ($rose(pins_i.latch_program_strobe) && ready_busy_pin_o
		&& ready_busy_pin_oe_o && pins_i.vpp_high && pins_i.prog_reset
		&& (pat == pflk_pkg::PAT_LOCK1 || pat == pflk_pkg::PAT_LOCK2
		|| pat == pflk_pkg::PAT_LOCK3) |-> ##[2:8] !ready_busy_pin_o)
		else $error("lock write did not show busy");
	AST_BUSY_MIN: assert property ($fell(ready_busy_pin_o) && ready_busy_pin_oe_o
		|-> !ready_busy_pin_o [*8])
		else $error("busy pulse too short");
	AST_BUSY_MAX: assert property (low_cnt <= RB_MAX)
		else $error("busy held too long");
	AST_CPU_BLOCK: assert property (!cpu_read_ok_o |-> cpu_code_o == 8'hFF)
		else $error("blocked code read leaked data");
	AST_CPU_GATE: assert property (!cpu_read_ok_o && !$past(rst_i) |-> $past(cpu_from_ext_i))
		else $error("code read blocked for an internal access");
	AST_DATA_OE: assert property (pins_i.vpp_high [*8] |=> !data_oe_o)
		else $error("data lines driven during a write");
endmodule : pflk_properties

/* pflk_prog_model.sv */
/*
 * Behavioural parallel programmer that drives the programming pins.
 * Assumes its tasks are called just after a rising clock edge.
 */
`timescale 1ns/100ps
module pflk_prog_model (
	// Clock.
	input  wire logic            clk_i,
	// Device side.
	input  wire logic [7:0]      data_i,
	output pflk_pkg::pflk_pins_t pins_o
);
	initial begin
		pins_o <= '{prog_reset: 1'b1, latch_program_strobe: 1'b1, ea_level: 1'b1, default: '0};
	end
	task automatic strap(input logic rst, input logic ea);
		pins_o.prog_reset <= rst;
		pins_o.ea_level <= ea;
	endtask : strap
	task automatic set_mode(input logic [3:0] pat, input logic [14:0] adr, input logic [7:0] dat);
		{pins_o.high_port_select_a, pins_o.high_port_select_b, pins_o.strobe_select_low_pin,
			pins_o.strobe_select_high_pin} <= pat;
		pins_o.serial_receive_pin <= adr[14];
		pins_o.addr <= adr[13:0];
		pins_o.data <= dat;
	endtask : set_mode
	task automatic op(input logic [3:0] pat, input logic [14:0] adr, input logic [7:0] dat,
		input int low);
		set_mode(pat, adr, dat);
		repeat (6) @(posedge clk_i);
		pins_o.vpp_high <= 1'b1;
		repeat (6) @(posedge clk_i);
		pins_o.latch_program_strobe <= 1'b0;
		repeat (low) @(posedge clk_i);
		pins_o.latch_program_strobe <= 1'b1;
		repeat (6) @(posedge clk_i);
		pins_o.vpp_high <= 1'b0;
		@(posedge clk_i);
	endtask : op
	task automatic rd(input logic [3:0] pat, input logic [14:0] adr, output logic [7:0] d);
		// Released data lines show the inverse of the last driven value.
		set_mode(pat, adr, ~pins_o.data);
		repeat (10) @(posedge clk_i);
		d = data_i;
	endtask : rd
endmodule : pflk_prog_model

/* tb.sv */
/*
 * Testbench of the flash programming port with bus tasks and a programmer model.
 * Assumes shortened write and erase counts; the array keeps its full size so
 * that the top programming address bit reaches real locations.
 */
`timescale 1ns/100ps
module tb;
	localparam logic [7:0] MAKER = 8'hC3; // Arbitrary identity value.
	localparam logic [7:0] PART  = 8'h3C; // Arbitrary identity value.
	logic                 clk_i;
	logic                 rst_i;
	pflk_pkg::pflk_pins_t pins;
	logic [7:0]           data_o;
	logic                 data_oe_o;
	logic                 rb;
	logic                 rb_oe;
	logic [14:0]          cpu_addr;
	logic                 cpu_ext;
	logic [7:0]           cpu_code;
	logic                 cpu_ok;
	logic                 ext_ok;
	logic                 cyc;
	logic                 we;
	logic [7:0]           adr;
	logic [31:0]          wdat;
	logic [31:0]          rdat;
	logic                 ack;
	logic [3:0]           sel;
	logic [31:0]          d;
	logic [7:0]           sig [3];
	int                   fails;
	int                   cmp_count;
	pflk_flash_port #(.WRITE_CYCLES(40), .ERASE_CYCLES(30), .ARRAY_BYTES(20480),
		.MAKER_CODE(MAKER), .PART_CODE(PART), .EA_POWERUP(1'b1)) pflk_flash_port_i (
		.clk_i(clk_i), .rst_i(rst_i), .pins_i(pins), .data_o(data_o), .data_oe_o(data_oe_o),
		.ready_busy_pin_o(rb), .ready_busy_pin_oe_o(rb_oe), .cpu_addr_i(cpu_addr),
		.cpu_from_ext_i(cpu_ext), .cpu_code_o(cpu_code), .cpu_read_ok_o(cpu_ok),
		.ext_exec_allowed_o(ext_ok), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
	pflk_prog_model pflk_prog_model_i (.clk_i(clk_i), .data_i(data_o), .pins_o(pins));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= v;
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		d = rdat;
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic wait_ready;
		repeat (21000) begin
			@(posedge clk_i);
			if (rb === 1'b1) break;
		end
	endtask : wait_ready
	task automatic rdc(input string n, input logic [3:0] p, input logic [14:0] a,
		input logic [7:0] e);
		logic [7:0] v;
		pflk_prog_model_i.rd(p, a, v);
		chk(n, {24'h0, e}, {24'h0, v});
		chk("data_oe", 32'h1, {31'h0, data_oe_o});
	endtask : rdc
	task automatic lvl(input logic [1:0] e);
		wb(1'b0, pflk_pkg::REG_STATUS, 32'h0);
		chk("level", {30'h0, e}, {30'h0, d[pflk_pkg::ST_LEVEL_LSB +: 2]});
	endtask : lvl
	task automatic op(input logic [3:0] p, input logic [14:0] a, input logic [7:0] v, input int l);
		pflk_prog_model_i.op(p, a, v, l);
	endtask : op
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	initial begin
		repeat (60000) @(posedge clk_i);
		fails++;
		report_and_stop();
	end
	initial begin
		rst_i <= 1'b1;
		{cyc, we, adr, wdat, cpu_addr, cpu_ext} <= '0;
		sel <= 4'hF;
		sig = '{MAKER, PART, pflk_pkg::SIG_VPP_12V};
		fails = 0;
		cmp_count = 0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		wait_ready();
		lvl(2'h0);
		rdc("blank", pflk_pkg::PAT_RD_CODE, 15'h4005, 8'hFF);
		op(pflk_pkg::PAT_WR_CODE, 15'h4005, 8'hA5, 3);
		rdc("poll", pflk_pkg::PAT_RD_CODE, 15'h4005, 8'h25);
		chk("busy", 32'h0, {31'h0, rb});
		wait_ready();
		rdc("byte", pflk_pkg::PAT_RD_CODE, 15'h4005, 8'hA5);
		rdc("top_bit", pflk_pkg::PAT_RD_CODE, 15'h0005, 8'hFF);
		op(pflk_pkg::PAT_WR_CODE, 15'h4005, 8'hF0, 3);
		wait_ready();
		rdc("rewrite", pflk_pkg::PAT_RD_CODE, 15'h4005, 8'hA0);
		op(pflk_pkg::PAT_WR_CODE, 15'h0010, 8'h3C, 3);
		op(pflk_pkg::PAT_WR_CODE, 15'h0010, 8'h00, 3);
		wait_ready();
		rdc("ignored", pflk_pkg::PAT_RD_CODE, 15'h0010, 8'h3C);
		for (int i = 0; i < 3; i++) begin
			rdc("sig", pflk_pkg::PAT_SIG, pflk_pkg::SIG_MAKER_ADR + 15'(i), sig[i]);
		end
		cpu_addr <= 15'h4005;
		cpu_ext <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("cpu_code", 32'hA0, {24'h0, cpu_code});
		op(pflk_pkg::PAT_LOCK1, 15'h0000, 8'h00, 3);
		wait_ready();
		lvl(2'h1);
		op(pflk_pkg::PAT_WR_CODE, 15'h0020, 8'h00, 3);
		chk("refused", 32'h1, {31'h0, rb});
		rdc("locked", pflk_pkg::PAT_RD_CODE, 15'h0020, 8'hFF);
		chk("ext_read", 32'h0, {31'h0, cpu_ok});
		cpu_ext <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk("int_read", 32'hA0, {24'h0, cpu_code});
		rdc("verify", pflk_pkg::PAT_RD_CODE, 15'h4005, 8'hA0);
		op(pflk_pkg::PAT_LOCK2, 15'h0000, 8'h00, 3);
		wait_ready();
		lvl(2'h2);
		rdc("no_verify", pflk_pkg::PAT_RD_CODE, 15'h4005, 8'hFF);
		op(pflk_pkg::PAT_LOCK3, 15'h0000, 8'h00, 3);
		wait_ready();
		lvl(2'h3);
		pflk_prog_model_i.strap(1'b1, 1'b0);
		repeat (8) @(posedge clk_i);
		pflk_prog_model_i.strap(1'b0, 1'b1);
		repeat (8) @(posedge clk_i);
		wb(1'b0, pflk_pkg::REG_STATUS, 32'h0);
		chk("ea_held", 32'h0, {31'h0, d[pflk_pkg::ST_EA_EFF]});
		pflk_prog_model_i.strap(1'b0, 1'b0);
		cpu_ext <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk("ext_exec", 32'h0, {31'h0, ext_ok});
		cpu_ext <= 1'b0;
		pflk_prog_model_i.strap(1'b1, 1'b1);
		op(pflk_pkg::PAT_ERASE, 15'h0000, 8'h00, 40);
		wait_ready();
		lvl(2'h0);
		rdc("erased", pflk_pkg::PAT_RD_CODE, 15'h4005, 8'hFF);
		pflk_prog_model_i.strap(1'b0, 1'b0);
		repeat (8) @(posedge clk_i);
		chk("ext_free", 32'h1, {31'h0, ext_ok});
		pflk_prog_model_i.strap(1'b1, 1'b1);
		wb(1'b0, pflk_pkg::REG_CTRL, 32'h0);
		chk("ctrl", 32'h1, d);
		sel <= 4'hE;
		wb(1'b1, pflk_pkg::REG_CTRL, 32'h0);
		sel <= 4'hF;
		wb(1'b0, pflk_pkg::REG_CTRL, 32'h0);
		chk("ctrl_sel", 32'h1, d);
		wb(1'b1, pflk_pkg::REG_CTRL, 32'h0);
		op(pflk_pkg::PAT_WR_CODE, 15'h0040, 8'h00, 3);
		wb(1'b1, pflk_pkg::REG_CTRL, 32'h1);
		rdc("port_off", pflk_pkg::PAT_RD_CODE, 15'h0040, 8'hFF);
		wb(1'b0, 8'h08, 32'h0);
		chk("unmapped", 32'h0, d);
		report_and_stop();
	end
endmodule : tb
bind pflk_flash_port pflk_properties #(.WRITE_CYCLES(WRITE_CYCLES),
	.ERASE_CYCLES(ERASE_CYCLES), .ARRAY_BYTES(ARRAY_BYTES)) pflk_properties_i (
	.clk_i(clk_i), .rst_i(rst_i), .pins_i(pins_i), .data_oe_o(data_oe_o),
	.ready_busy_pin_o(ready_busy_pin_o), .ready_busy_pin_oe_o(ready_busy_pin_oe_o),
	.cpu_from_ext_i(cpu_from_ext_i), .cpu_code_o(cpu_code_o), .cpu_read_ok_o(cpu_read_ok_o),
	.ext_exec_allowed_o(ext_exec_allowed_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o));
